// File: src/spr_defines.svh
// Purpose: Constants for the stack pointer register pair.
// Assumes: Register addresses are 8 bits in the control register space.
// Notes: Definitions only.
`ifndef SPR_DEFINES_SVH
`define SPR_DEFINES_SVH
`define SPR_ADDR_HIGH 8'hD8
`define SPR_ADDR_LOW 8'hD9
`define SPR_STEP 16'h0001
`define SPR_ZERO_BYTE 8'h00
`define SPR_FULL_BYTE 8'hFF
`define SPR_BYTE_STEP 8'h01
`endif

// File: src/spr_pkg.sv
// Purpose: Types for the stack pointer register pair.
// Assumes: Nothing beyond the constants header.
// Notes: Holds the access mode and stack operation types.
package spr_pkg;
  typedef enum logic [1:0] {SPR_MODE_DIRECT, SPR_MODE_INDIRECT, SPR_MODE_INDEXED} spr_mode_t;
  typedef enum logic [1:0] {SPR_OP_NONE, SPR_OP_PUSH, SPR_OP_POP} spr_op_t;
endpackage

// File: src/spr_stack_pointer_regs.sv
// Purpose: Stack pointer high and low byte registers with push and pop stepping.
// Assumes: Register port and stack requests are synchronous to i_clock.
// Notes: Contents are not initialised by reset; software loads them.
`timescale 1ns/1ps
`default_nettype none
`include "spr_defines.svh"

module spr_stack_pointer_regs
  import spr_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rstn,
  input wire logic i_reg_write,
  input wire logic i_reg_read,
  input wire logic [7:0] i_reg_addr,
  input wire spr_mode_t i_reg_mode,
  input wire logic [7:0] i_reg_wdata,
  input wire spr_op_t i_stack_op,
  output logic [7:0] o_reg_rdata,
  output logic o_reg_hit,
  output logic [15:0] o_stack_address,
  output logic o_stack_address_valid,
  output logic [15:0] o_stack_pointer_value
);

  logic [7:0] stack_ptr_high_byte;
  logic [7:0] stack_ptr_low_byte;
  logic [15:0] stack_pointer_value;
  logic [15:0] next_stack_pointer_value;
  logic direct_high;
  logic direct_low;

  function automatic logic selects(input logic [7:0] addr, input spr_mode_t mode,
                                   input logic [7:0] target);
    selects = (addr == target) && (mode == SPR_MODE_DIRECT);
  endfunction

  assign direct_high = selects(i_reg_addr, i_reg_mode, `SPR_ADDR_HIGH);
  assign direct_low = selects(i_reg_addr, i_reg_mode, `SPR_ADDR_LOW);
  assign stack_pointer_value = {stack_ptr_high_byte, stack_ptr_low_byte};

  // A direct register write wins over a stack step in the same cycle for the byte it writes; the other byte still steps.
  always_comb begin
    next_stack_pointer_value = stack_pointer_value;
    case (i_stack_op)
      SPR_OP_PUSH: next_stack_pointer_value = stack_pointer_value - `SPR_STEP;
      SPR_OP_POP: next_stack_pointer_value = stack_pointer_value + `SPR_STEP;
      default: next_stack_pointer_value = stack_pointer_value;
    endcase
  end

  // Reset is deliberately absent: contents stay as they were.
  always_ff @(posedge i_clock) begin
    if (i_reg_write && direct_high) begin
      stack_ptr_high_byte <= i_reg_wdata;
    end else begin
      stack_ptr_high_byte <= next_stack_pointer_value[15:8];
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_reg_write && direct_low) begin
      stack_ptr_low_byte <= i_reg_wdata;
    end else begin
      stack_ptr_low_byte <= next_stack_pointer_value[7:0];
    end
  end

  // Push addresses the decremented pointer; pop addresses the current one.
  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      o_stack_address <= {`SPR_ZERO_BYTE, `SPR_ZERO_BYTE};
      o_stack_address_valid <= 1'b0;
    end else begin
      o_stack_address_valid <= (i_stack_op == SPR_OP_PUSH) || (i_stack_op == SPR_OP_POP);
      if (i_stack_op == SPR_OP_PUSH) begin
        o_stack_address <= next_stack_pointer_value;
      end else begin
        o_stack_address <= stack_pointer_value;
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      o_reg_rdata <= `SPR_ZERO_BYTE;
      o_reg_hit <= 1'b0;
    end else begin
      o_reg_hit <= (i_reg_read || i_reg_write) && (direct_high || direct_low);
      if (i_reg_read && direct_high) begin
        o_reg_rdata <= stack_ptr_high_byte;
      end else if (i_reg_read && direct_low) begin
        o_reg_rdata <= stack_ptr_low_byte;
      end else begin
        o_reg_rdata <= `SPR_ZERO_BYTE;
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      o_stack_pointer_value <= {`SPR_ZERO_BYTE, `SPR_ZERO_BYTE};
    end else begin
      o_stack_pointer_value <= stack_pointer_value;
    end
  end

  a_push_decrements: assert property (@(posedge i_clock) disable iff (!i_rstn)
    (i_stack_op == SPR_OP_PUSH && !i_reg_write) |=>
      stack_pointer_value == $past(stack_pointer_value) - `SPR_STEP)
    else $error("Push did not decrement the pointer.");

  a_pop_increments: assert property (@(posedge i_clock) disable iff (!i_rstn)
    (i_stack_op == SPR_OP_POP && !i_reg_write) |=>
      stack_pointer_value == $past(stack_pointer_value) + `SPR_STEP)
    else $error("Pop did not increment the pointer.");

  a_push_address: assert property (@(posedge i_clock) disable iff (!i_rstn)
    (i_stack_op == SPR_OP_PUSH) |=>
      (o_stack_address_valid && o_stack_address == $past(stack_pointer_value) - `SPR_STEP))
    else $error("Push address is not the pointer minus one.");

  a_pop_address: assert property (@(posedge i_clock) disable iff (!i_rstn)
    (i_stack_op == SPR_OP_POP) |=>
      (o_stack_address_valid && o_stack_address == $past(stack_pointer_value)))
    else $error("Pop address is not the current pointer.");

  a_carry_high: assert property (@(posedge i_clock) disable iff (!i_rstn)
    (i_stack_op == SPR_OP_POP && !i_reg_write && stack_ptr_low_byte == `SPR_FULL_BYTE) |=>
      (stack_ptr_low_byte == `SPR_ZERO_BYTE &&
       stack_ptr_high_byte == $past(stack_ptr_high_byte) + `SPR_BYTE_STEP))
    else $error("Low byte overflow did not carry into the high byte.");

  a_write_high: assert property (@(posedge i_clock) disable iff (!i_rstn)
    (i_reg_write && direct_high) |=> stack_ptr_high_byte == $past(i_reg_wdata))
    else $error("High byte write was not stored.");

  a_write_low: assert property (@(posedge i_clock) disable iff (!i_rstn)
    (i_reg_write && direct_low) |=> stack_ptr_low_byte == $past(i_reg_wdata))
    else $error("Low byte write was not stored.");

  a_indirect_ignored: assert property (@(posedge i_clock) disable iff (!i_rstn)
    (i_reg_write && i_reg_mode != SPR_MODE_DIRECT && i_stack_op == SPR_OP_NONE) |=>
      (stack_pointer_value == $past(stack_pointer_value) && !o_reg_hit))
    else $error("Non-direct access reached the stack pointer.");

  a_value_view: assert property (@(posedge i_clock) disable iff (!i_rstn)
    ##1 o_stack_pointer_value == $past({stack_ptr_high_byte, stack_ptr_low_byte}))
    else $error("Visible pointer is not high byte above low byte.");

  a_push_borrow: assert property (@(posedge i_clock) disable iff (!i_rstn)
    (i_stack_op == SPR_OP_PUSH && !i_reg_write && stack_ptr_low_byte == `SPR_ZERO_BYTE) |=>
      (stack_ptr_low_byte == `SPR_FULL_BYTE &&
       stack_ptr_high_byte == $past(stack_ptr_high_byte) - `SPR_BYTE_STEP))
    else $error("Low byte underflow did not borrow from the high byte.");

  // A step that does not wrap the low byte must leave the high byte alone.
  a_push_high_kept: assert property (@(posedge i_clock) disable iff (!i_rstn)
    (i_stack_op == SPR_OP_PUSH && !i_reg_write && stack_ptr_low_byte != `SPR_ZERO_BYTE) |=>
      stack_ptr_high_byte == $past(stack_ptr_high_byte))
    else $error("Push changed the high byte without a borrow.");

  a_pop_high_kept: assert property (@(posedge i_clock) disable iff (!i_rstn)
    (i_stack_op == SPR_OP_POP && !i_reg_write && stack_ptr_low_byte != `SPR_FULL_BYTE) |=>
      stack_ptr_high_byte == $past(stack_ptr_high_byte))
    else $error("Pop changed the high byte without a carry.");

  // Reads return the byte as it stood at the request edge.
  a_read_high: assert property (@(posedge i_clock) disable iff (!i_rstn)
    (i_reg_read && direct_high) |=>
      o_reg_rdata == $past(stack_ptr_high_byte))
    else $error("High byte read returned a wrong value.");

  a_read_low: assert property (@(posedge i_clock) disable iff (!i_rstn)
    (i_reg_read && direct_low) |=>
      o_reg_rdata == $past(stack_ptr_low_byte))
    else $error("Low byte read returned a wrong value.");

  a_write_hit: assert property (@(posedge i_clock) disable iff (!i_rstn)
    (i_reg_write && i_reg_mode == SPR_MODE_DIRECT && i_reg_addr == `SPR_ADDR_HIGH) |=>
      o_reg_hit)
    else $error("Direct write to the high byte was not acknowledged.");

  // Misses answer with zero data and no hit.
  a_read_miss: assert property (@(posedge i_clock) disable iff (!i_rstn)
    (i_reg_read && !i_reg_write && (i_reg_mode != SPR_MODE_DIRECT ||
     (i_reg_addr != `SPR_ADDR_HIGH && i_reg_addr != `SPR_ADDR_LOW))) |=>
      (o_reg_rdata == `SPR_ZERO_BYTE && !o_reg_hit))
    else $error("Missed read did not answer with zero.");

  // Without a step or a write the pointer must hold.
  a_idle_kept: assert property (@(posedge i_clock) disable iff (!i_rstn)
    (i_stack_op == SPR_OP_NONE && !i_reg_write) |=>
      $stable(stack_pointer_value))
    else $error("Pointer moved without a stack step.");

  a_valid_idle: assert property (@(posedge i_clock) disable iff (!i_rstn)
    (i_stack_op == SPR_OP_NONE) |=>
      !o_stack_address_valid)
    else $error("Stack address marked valid without a step.");

  a_high_write_alone: assert property (@(posedge i_clock) disable iff (!i_rstn)
    (i_reg_write && direct_high && i_stack_op == SPR_OP_NONE) |=>
      stack_ptr_low_byte == $past(stack_ptr_low_byte))
    else $error("High byte write disturbed the low byte.");

  // A push right after a low byte write must step from the written value.
  a_write_then_push: assert property (@(posedge i_clock) disable iff (!i_rstn)
    (i_reg_write && direct_low && i_stack_op == SPR_OP_NONE) ##1
      (i_stack_op == SPR_OP_PUSH && !i_reg_write) |=>
      o_stack_address[7:0] == $past(i_reg_wdata, 2) - `SPR_BYTE_STEP)
    else $error("Push did not use the freshly written low byte.");

endmodule
`default_nettype wire

// File: tb/spr_tb.sv
// Purpose: Self-checking bench for the stack pointer register pair.
// Assumes: Every answer comes one edge after its request.
// Notes: The bench keeps its own pointer copy to predict addresses.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import spr_pkg::*;
  logic i_clock = 0, i_rstn = 0, i_reg_write = 0, i_reg_read = 0;
  logic [7:0] i_reg_addr = 8'h00, i_reg_wdata = 8'h00, o_reg_rdata;
  spr_mode_t i_reg_mode = SPR_MODE_DIRECT;
  spr_op_t i_stack_op = SPR_OP_NONE;
  logic o_reg_hit, o_stack_address_valid;
  logic [15:0] o_stack_address, o_stack_pointer_value, ptr;
  int n_errors = 0, n_compared = 0, cyc = 0;
  spr_stack_pointer_regs spr_stack_pointer_regs_i (.i_clock, .i_rstn, .i_reg_write,
    .i_reg_read, .i_reg_addr, .i_reg_mode, .i_reg_wdata, .i_stack_op, .o_reg_rdata,
    .o_reg_hit, .o_stack_address, .o_stack_address_valid, .o_stack_pointer_value);
  always #5 i_clock = ~i_clock;
  task automatic stop_test;
    if (n_errors == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  always @(posedge i_clock) begin
    cyc++;
    if (cyc == 2000) begin
      n_errors++;
      stop_test();
    end
  end
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  function automatic logic [15:0] stepped(input spr_op_t o, input logic [15:0] p);
    return (o == SPR_OP_PUSH) ? p - 16'h0001 : p + 16'h0001;
  endfunction
  // Each request is driven just after an edge and checked one edge later.
  task automatic acc(input logic w, input logic [7:0] a, input spr_mode_t m,
                     input logic [7:0] d, input logic h, input logic [7:0] r);
    i_stack_op = SPR_OP_NONE;
    i_reg_write = w;
    i_reg_read = ~w;
    i_reg_addr = a;
    i_reg_mode = m;
    i_reg_wdata = d;
    @(posedge i_clock);
    #1;
    chk("hit", {15'h0000, o_reg_hit}, {15'h0000, h});
    chk("rdata", {8'h00, o_reg_rdata}, {8'h00, r});
    chk("idle", {15'h0000, o_stack_address_valid}, 16'h0000);
  endtask
  task automatic load(input logic [15:0] v);
    acc(1, 8'hD8, SPR_MODE_DIRECT, v[15:8], 1, 8'h00);
    acc(1, 8'hD9, SPR_MODE_DIRECT, v[7:0], 1, 8'h00);
    acc(0, 8'hD8, SPR_MODE_DIRECT, 8'h00, 1, v[15:8]);
    acc(0, 8'hD9, SPR_MODE_DIRECT, 8'h00, 1, v[7:0]);
    ptr = v;
    chk("value", o_stack_pointer_value, v);
  endtask
  task automatic step(input spr_op_t o);
    i_reg_write = 0;
    i_reg_read = 0;
    i_stack_op = o;
    @(posedge i_clock);
    #1;
    chk("valid", {15'h0000, o_stack_address_valid}, 16'h0001);
    chk("addr", o_stack_address, (o == SPR_OP_PUSH) ? stepped(o, ptr) : ptr);
    ptr = stepped(o, ptr);
  endtask
  initial begin
    void'($urandom(13066));
    // The bytes power up unknown, so they are loaded while reset is still held.
    @(posedge i_clock);
    #1;
    acc(1, 8'hD8, SPR_MODE_DIRECT, 8'h00, 0, 8'h00);
    acc(1, 8'hD9, SPR_MODE_DIRECT, 8'h00, 0, 8'h00);
    @(posedge i_clock);
    #1;
    i_rstn = 1;
    load(16'h00FF);
    repeat (4) step(SPR_OP_PUSH);
    repeat (4) step(SPR_OP_POP);
    acc(0, 8'hD9, SPR_MODE_DIRECT, 8'h00, 1, 8'hFF);
    load(16'h3700);
    step(SPR_OP_PUSH);
    acc(0, 8'hD8, SPR_MODE_DIRECT, 8'h00, 1, 8'h36);
    load(16'h12FF);
    step(SPR_OP_POP);
    acc(0, 8'hD8, SPR_MODE_DIRECT, 8'h00, 1, 8'h13);
    // Indirect, indexed and unmapped accesses must leave the bytes alone.
    acc(1, 8'hD9, SPR_MODE_INDIRECT, 8'h55, 0, 8'h00);
    acc(1, 8'hD8, SPR_MODE_INDEXED, 8'h55, 0, 8'h00);
    acc(0, 8'hD9, SPR_MODE_INDEXED, 8'h00, 0, 8'h00);
    acc(0, 8'hDA, SPR_MODE_DIRECT, 8'h00, 0, 8'h00);
    acc(0, 8'hD9, SPR_MODE_DIRECT, 8'h00, 1, 8'h00);
    acc(0, 8'hD8, SPR_MODE_DIRECT, 8'h00, 1, 8'h13);
    // A push right after a low byte write steps from the written value.
    acc(1, 8'hD9, SPR_MODE_DIRECT, 8'h80, 1, 8'h00);
    ptr = 16'h1380;
    step(SPR_OP_PUSH);
    repeat (30) begin
      load(16'($urandom));
      step($urandom % 2 ? SPR_OP_PUSH : SPR_OP_POP);
      step($urandom % 2 ? SPR_OP_PUSH : SPR_OP_POP);
    end
    stop_test();
  end
endmodule
`default_nettype wire
